// ---- design/mtsc_codec.sv ----
// Manchester and three-of-six byte codec behind a classic Wishbone slave.
// Assumes one clock, synchronous active-high reset, single-cycle master.
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module mtsc_codec
  import mtsc_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Write enable
  input wire logic [3:0] adr_i, // Byte address
  input wire logic [3:0] sel_i, // Byte selects
  input wire logic [31:0] dat_i, // Write data
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Acknowledge
  output logic ready_o, // Ready flag copy
  output logic error_o // Error flag copy
);

  // ****************************************
  // Coding functions
  // ****************************************

  // Manchester nibble to byte, msb first, 0->10 1->01
  // Odd bit of each pair is the first half on the line
  function automatic logic [7:0] man_enc(input logic [3:0] n);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 4; i++) begin
      b[2*i+1] = ~n[i];
      b[2*i] = n[i];
    end
    return b;
  endfunction : man_enc

  // Manchester byte to nibble; bit 4 flags a bad pair
  // Equal halves of a pair can never come from the encoder
  function automatic logic [4:0] man_dec(input logic [7:0] b);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 4; i++) begin
      r[i] = b[2*i];
      if (b[2*i+1] == b[2*i]) begin
        r[4] = 1'b1;
      end
    end
    return r;
  endfunction : man_dec

  // Three-of-six nibble to symbol
  // Every symbol holds three ones, keeping the line balanced
  function automatic logic [5:0] tos_enc(input logic [3:0] n);
    logic [5:0] s;
    s = 6'h00;
    case (n)
      4'h0: s = 6'h16;
      4'h1: s = 6'h0d;
      4'h2: s = 6'h0e;
      4'h3: s = 6'h0b;
      4'h4: s = 6'h1c;
      4'h5: s = 6'h19;
      4'h6: s = 6'h1a;
      4'h7: s = 6'h13;
      4'h8: s = 6'h2c;
      4'h9: s = 6'h25;
      4'ha: s = 6'h26;
      4'hb: s = 6'h23;
      4'hc: s = 6'h34;
      4'hd: s = 6'h31;
      4'he: s = 6'h32;
      default: s = 6'h29;
    endcase
    return s;
  endfunction : tos_enc

  // Symbol to nibble by searching the table; bit 4 flags no match
  // One table serves both ways; the price is sixteen compares
  function automatic logic [4:0] tos_dec(input logic [5:0] s);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 0; i < 16; i++) begin
      if (tos_enc(4'(i)) == s) begin
        r = {1'b0, 4'(i)};
      end
    end
    return r;
  endfunction : tos_dec

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] low_r;
  logic [7:0] mid_r; // Middle data
  logic [7:0] high_r; // High data
  logic mode_r; // 0 Manchester, 1 three-of-six
  logic dma_r; // Stored, no effect here
  logic endian_r; // Stored, no effect here
  logic dec_r; // Decode start, self clearing
  logic enc_r; // Encode start, self clearing
  logic error_r; // Sticky error
  logic ready_r; // Sticky ready
  logic ack_r; // Bus acknowledge
  logic [31:0] rdat_r; // Registered read data
  mtsc_state_t state_r; // Engine state
  logic [1:0] cnt_r; // Latency counter
  logic op_enc_r; // Latched operation kind
  logic [7:0] res_low; // Result bytes
  logic [7:0] res_mid;
  logic [7:0] res_high;
  logic res_err; // Result error
  logic done; // Results written this cycle
  mtsc_req_t req; // Bundled request
  logic wr_ctrl; // Control byte written
  logic [7:0] wbyte; // Low write byte

  // Bus signals travel bundled
  assign req = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};
  assign wbyte = req.dat[7:0];
  // Take a request once; ack pulses one cycle
  assign wr_ctrl = cyc_i && stb_i && !ack_r && req.we && req.sel[0] &&
                   req.adr == MTSC_OFF_CTRL;
  assign done = (state_r == MTSC_DONE);
  assign ack_o = ack_r;
  assign dat_o = rdat_r;
  assign ready_o = ready_r;
  assign error_o = error_r;

  // ****************************************
  // Combinational codec unit
  // ****************************************
  // Pure function of the data registers, the mode bit and the latched operation
  // Operands stay put from launch to write-back, so no extra latching
  always_comb begin
    logic [4:0] a;
    logic [4:0] b;
    logic [4:0] c;
    logic [4:0] d;
    logic [23:0] w;
    a = 5'h00;
    b = 5'h00;
    c = 5'h00;
    d = 5'h00;
    w = {high_r, mid_r, low_r};
    res_low = low_r;
    res_mid = mid_r;
    res_high = high_r;
    res_err = 1'b0;
    if (!mode_r && op_enc_r) begin
      // Manchester encode
      res_mid = man_enc(low_r[7:4]);
      res_low = man_enc(low_r[3:0]);
      res_high = high_r;
    end else if (!mode_r) begin
      // Manchester decode
      a = man_dec(mid_r);
      b = man_dec(low_r);
      res_err = a[4] | b[4];
      res_mid = 8'h00;
      res_low = res_err ? 8'hff : {a[3:0], b[3:0]};
    end else if (op_enc_r) begin
      // Three-of-six encode
      w = {tos_enc(mid_r[7:4]), tos_enc(mid_r[3:0]),
           tos_enc(low_r[7:4]), tos_enc(low_r[3:0])};
      {res_high, res_mid, res_low} = w;
    end else begin
      // Three-of-six decode
      a = tos_dec(w[23:18]);
      b = tos_dec(w[17:12]);
      c = tos_dec(w[11:6]);
      d = tos_dec(w[5:0]);
      res_err = a[4] | b[4] | c[4] | d[4];
      res_high = 8'h00;
      {res_mid, res_low} = res_err ? 16'hffff :
        {a[3:0], b[3:0], c[3:0], d[3:0]};
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************

  // Ack one cycle after strobe, drop after one cycle
  // A held strobe is not taken twice: ack masks the second edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i && stb_i && !ack_r;
    end
  end

  // Read mux; unmapped offsets read zero
  // Registered, so read data stands together with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_r) begin
      case (req.adr)
        MTSC_OFF_LOW: rdat_r <= {24'h000000, low_r};
        MTSC_OFF_MID: rdat_r <= {24'h000000, mid_r};
        MTSC_OFF_HIGH: rdat_r <= {24'h000000, high_r};
        MTSC_OFF_CTRL: rdat_r <= {24'h000000, ready_r, error_r, enc_r, dec_r,
                                  1'b0, endian_r, dma_r, mode_r};
        default: rdat_r <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Data registers
  // ****************************************

  // Host writes hold until results overwrite them
  // Results land in the same registers the operands came from
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_r <= MTSC_DATA_RST;
      mid_r <= MTSC_DATA_RST;
      high_r <= MTSC_DATA_RST;
    end else if (done) begin
      low_r <= res_low;
      mid_r <= res_mid;
      high_r <= res_high;
    end else if (cyc_i && stb_i && !ack_r && req.we && req.sel[0]) begin
      // Writes while busy would corrupt operands, so they are acked but dropped
      if (state_r == MTSC_IDLE) begin
        case (req.adr)
          MTSC_OFF_LOW: low_r <= wbyte;
          MTSC_OFF_MID: mid_r <= wbyte;
          MTSC_OFF_HIGH: high_r <= wbyte;
          default: low_r <= low_r;
        endcase
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************

  // Plain config bits
  // Mode cannot change under a running operation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= MTSC_CTRL_RST[MTSC_BIT_MODE];
      dma_r <= MTSC_CTRL_RST[MTSC_BIT_DMA];
      endian_r <= MTSC_CTRL_RST[MTSC_BIT_ENDIAN];
    end else if (wr_ctrl && state_r == MTSC_IDLE) begin
      mode_r <= wbyte[MTSC_BIT_MODE];
      dma_r <= wbyte[MTSC_BIT_DMA];
      endian_r <= wbyte[MTSC_BIT_ENDIAN];
    end
  end

  // Start bits: set by write, cleared at launch
  // Encode takes priority when both start bits are written
  // Starts are refused while the engine is busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enc_r <= MTSC_CTRL_RST[MTSC_BIT_ENC];
      dec_r <= MTSC_CTRL_RST[MTSC_BIT_DEC];
    end else if (state_r == MTSC_IDLE && (enc_r || dec_r)) begin
      enc_r <= 1'b0;
      dec_r <= 1'b0;
    end else if (wr_ctrl && state_r == MTSC_IDLE) begin
      enc_r <= wbyte[MTSC_BIT_ENC];
      dec_r <= wbyte[MTSC_BIT_DEC] && !wbyte[MTSC_BIT_ENC];
    end
  end

  // Sticky flags: completion sets win over a simultaneous clear
  // Error gathers over operations until software clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_r <= MTSC_CTRL_RST[MTSC_BIT_READY];
      error_r <= MTSC_CTRL_RST[MTSC_BIT_ERROR];
    end else if (done) begin
      ready_r <= 1'b1;
      error_r <= error_r | res_err;
    end else if (wr_ctrl) begin
      ready_r <= wbyte[MTSC_BIT_READY];
      error_r <= wbyte[MTSC_BIT_ERROR];
    end
  end

  // ****************************************
  // Engine sequencing
  // ****************************************

  // Launch, wait fixed cycles, write back
  // The wait is fixed so software can poll with a known bound
  // Start bits are read at launch, one cycle after the write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= MTSC_IDLE;
      cnt_r <= 2'h0;
      op_enc_r <= 1'b0;
    end else begin
      case (state_r)
        MTSC_IDLE: begin
          // Wait for a start bit
          if (enc_r || dec_r) begin
            state_r <= MTSC_RUN;
            op_enc_r <= enc_r;
            cnt_r <= MTSC_BUSY_CYCLES;
          end
        end
        MTSC_RUN: begin
          // Count down the fixed latency
          if (cnt_r <= 2'h1) begin
            state_r <= MTSC_DONE;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        // Results are written back in this state
        MTSC_DONE: state_r <= MTSC_IDLE;
        default: state_r <= MTSC_IDLE;
      endcase
    end
  end

endmodule : mtsc_codec

// ---- design/mtsc_pkg.sv ----
// Package for the Manchester / three-of-six codec: offsets, fields, resets, timing.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package mtsc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] MTSC_OFF_LOW = 4'h0; // Low data register
  localparam logic [3:0] MTSC_OFF_MID = 4'h4; // Middle data register
  localparam logic [3:0] MTSC_OFF_HIGH = 4'h8; // High data register
  localparam logic [3:0] MTSC_OFF_CTRL = 4'hc; // Control register

  // ****************************************
  // Control fields
  // ****************************************
  localparam int MTSC_BIT_MODE = 0; // 1 = three-of-six
  localparam int MTSC_BIT_DMA = 1; // Stored only
  localparam int MTSC_BIT_ENDIAN = 2; // Stored only
  localparam int MTSC_BIT_DEC = 4; // Decode start
  localparam int MTSC_BIT_ENC = 5; // Encode start
  localparam int MTSC_BIT_ERROR = 6; // Decode error flag
  localparam int MTSC_BIT_READY = 7; // Completion flag
  localparam logic [7:0] MTSC_CTRL_RST = 8'h00; // Control after reset
  localparam logic [7:0] MTSC_DATA_RST = 8'h00; // Data after reset

  // ****************************************
  // Timing
  // ****************************************
  localparam logic [1:0] MTSC_BUSY_CYCLES = 2'h1; // Cycles in the run state; results land one cycle later

  // Bus request bundle
  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } mtsc_req_t;

  // Engine states
  typedef enum logic [1:0] {
    MTSC_IDLE = 2'b00,
    MTSC_RUN = 2'b01,
    MTSC_DONE = 2'b10
  } mtsc_state_t;

endpackage : mtsc_pkg

// ---- tb/mtsc_codec_checker.sv ----
// Checker for bus timing and flags of the codec.
// Bound to mtsc_codec; sees only its ports.
`timescale 1ns/1ps
module mtsc_codec_checker
  import mtsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic ready_o,
  input wire logic error_o
);
  // ****
  // Steps
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken at this edge
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  // Taken control write that starts work
  sequence go_s;
    req_s ##0 we_i && sel_i[0] && adr_i == MTSC_OFF_CTRL && (dat_i[5] || dat_i[4]);
  endsequence
  ack_resp_a: assert property (req_s |=> ack_o) else $error("no ack");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("long ack");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  read_width_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("wide");
  op_latency_a: assert property (go_s |-> ##[1:6] ready_o) else $error("slow op");
  ready_keep_a: assert property ($fell(ready_o) |-> $past(we_i && adr_i == MTSC_OFF_CTRL))
    else $error("ready lost");
  err_ready_a: assert property ($rose(error_o) |-> $rose(ready_o)) else $error("err alone");
  start_clear_a: assert property (ack_o && $past(!we_i && adr_i == MTSC_OFF_CTRL)
    |-> dat_o[5:4] == 2'h0 && dat_o[7:6] == {$past(ready_o), $past(error_o)}) else $error("ctrl");
endmodule : mtsc_codec_checker

bind mtsc_codec mtsc_codec_checker mtsc_codec_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .ready_o(ready_o), .error_o(error_o));

// ---- tb/mtsc_codec_tb.sv ----
// Bench for the codec: Wishbone tasks, encode and decode runs, flags.
// Assumes one 40 MHz clock and a synchronous reset.
`timescale 1ns/1ps
module mtsc_codec_tb
  import mtsc_pkg::*;
;
  logic clk_i = 1'b0; // Clock
  logic rst_i = 1'b1; // Reset
  logic cyc_i = 1'b0; // Cycle
  logic stb_i = 1'b0; // Strobe
  logic we_i = 1'b0; // Direction
  logic [3:0] adr_i = 4'h0; // Address
  logic [3:0] sel_i = 4'h0; // Selects
  logic [31:0] dat_i = 32'h0; // Write data
  logic [31:0] dat_o; // Read data
  logic ack_o, ready_o, error_o; // Answers
  int fails = 0, cmp_count = 0, cyc_n = 0; // Counters
  logic [31:0] q, h, m, l, c; // Last read, results, control
  // Six-bit symbols, nibble 0 first
  localparam logic [5:0] T6 [16] = '{6'h16, 6'h0d, 6'h0e, 6'h0b, 6'h1c, 6'h19, 6'h1a,
    6'h13, 6'h2c, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32, 6'h29};
  always #12.5 clk_i = ~clk_i;
  mtsc_codec mtsc_codec_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ready_o(ready_o), .error_o(error_o));
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Manchester byte of a nibble, msb first
  function automatic logic [7:0] man(input logic [3:0] n);
    for (int i = 0; i < 4; i++) begin
      man[2*i +: 2] = n[i] ? 2'b01 : 2'b10;
    end
  endfunction : man
  // One classic cycle; held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb
  // Load operands, start, poll ready, read back
  task automatic run(input logic [7:0] op, hi, mi, lo);
    int n;
    wb(1'b1, MTSC_OFF_HIGH, hi);
    wb(1'b1, MTSC_OFF_MID, mi);
    wb(1'b1, MTSC_OFF_LOW, lo);
    wb(1'b0, MTSC_OFF_LOW, 8'h0);
    chk(q, {24'h0, lo});
    wb(1'b1, MTSC_OFF_CTRL, op);
    n = 0;
    do begin
      wb(1'b0, MTSC_OFF_CTRL, 8'h0);
      n++;
    end while (q[7] !== 1'b1 && n < 8);
    c = q;
    chk(c[7], 32'h1);
    chk(c[5:4], 32'h0);
    wb(1'b0, MTSC_OFF_HIGH, 8'h0);
    h = q;
    wb(1'b0, MTSC_OFF_MID, 8'h0);
    m = q;
    wb(1'b0, MTSC_OFF_LOW, 8'h0);
    l = q;
  endtask : run
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    for (int i = 0; i < 16; i += 4) begin
      wb(1'b0, 4'(i), 8'h0);
      chk(q, 32'h0);
    end
    wb(1'b1, 4'h2, 8'h55);
    wb(1'b0, 4'h2, 8'h0);
    chk(q, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_man();
    logic [7:0] b [3] = '{8'h0f, 8'hf0, 8'h5a};
    foreach (b[i]) begin
      run(8'h20, 8'h77, 8'h00, b[i]);
      chk(h, 32'h77);
      chk(m, {24'h0, man(b[i][7:4])});
      chk(l, {24'h0, man(b[i][3:0])});
      run(8'h10, 8'h00, m[7:0], l[7:0]);
      chk(l, {24'h0, b[i]});
      chk({m[7:0], c[6]}, 32'h0);
    end
    $display("manchester test done");
  endtask : t_man
  task automatic t_err();
    run(8'h10, 8'h00, 8'haa, 8'hab);
    chk({l[7:0], c[6], error_o}, 32'h3ff);
    repeat (20) @(posedge clk_i);
    chk(ready_o, 32'h1);
    wb(1'b1, MTSC_OFF_CTRL, 8'h06);
    wb(1'b0, MTSC_OFF_CTRL, 8'h0);
    chk(q, 32'h06);
    wb(1'b1, MTSC_OFF_CTRL, 8'h00);
    wb(1'b0, MTSC_OFF_CTRL, 8'h0);
    chk(q, 32'h0);
    run(8'h30, 8'h00, 8'h00, 8'h5a);
    chk({m[7:0], l[7:0]}, {16'h0, man(4'h5), man(4'ha)});
    $display("error test done");
  endtask : t_err
  task automatic t_tos();
    run(8'h21, 8'h00, 8'h01, 8'h23);
    chk({h[7:0], m[7:0], l[7:0]}, {8'h0, T6[0], T6[1], T6[2], T6[3]});
    run(8'h11, h[7:0], m[7:0], l[7:0]);
    chk({h[7:0], m[7:0], l[7:0], c[6]}, 32'h246);
    run(8'h11, 8'hff, 8'hff, 8'hff);
    chk({m[7:0], l[7:0], c[6]}, 32'h1ffff);
    $display("three of six test done");
  endtask : t_tos
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 4000) begin
      fails++;
      $display("unexpected at %0t: timeout", $time);
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_man();
    t_err();
    t_tos();
    final_report();
  end
endmodule : mtsc_codec_tb
